/* core/acfg_top.v */
`timescale 1ns/10ps
`include "acfg_defines.vh"

// How it works
// - Each of the 24 output-driver disable bits turns its output pin driver off when 1 and leaves it on when 0.
// - While whole-chip sleep is active, every internal block whose mask bit does not exempt it is powered down.
// - Mask bit 5 set keeps the bias currents powered during whole-chip sleep; clear lets them sleep.
// - Mask bit 3 set keeps the sampling clock input buffer running during whole-chip sleep; clear lets it sleep.
// - Mask bit 2 set keeps the reference amplifier awake during whole-chip sleep; clear lets it sleep.
// - Mask bit 1 is inverted: set puts the bandgap to sleep with the chip, clear keeps the bandgap powered.
// - Sync register bit 7 clear makes a high shared pin put the chip to sleep; set makes a rising pin edge a sync command.
// - Sync register bit 5 set makes the register toggle the sync source instead of the pin; clear disables it.
// - Toggling bit 6 with register sync enabled issues one sync command, and the bit is never cleared by hardware.
// - Bit 3 clear gives the reference buffer pin the reference choice; set hands it to bits 2-1 and bit 0.
// - Reference field codes are 00 internal, 01 external buffered, 10 external, 11 unused, under register control.
// - Bit 0 under register control selects the single-ended clock and shuts the differential clock buffer.
// - Analog control bit 5 selects single-ended analog input when set and differential input when clear.
module acfg_top #(
	parameter DRV_COUNT = 24
) (
	input wire clock,
	input wire rst,
	input wire [`ACFG_ADDR_W-1:0] reg_addr,
	input wire [`ACFG_DATA_W-1:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [`ACFG_DATA_W-1:0] reg_rdata,
	output reg reg_rvalid,
	input wire whole_chip_sleep,
	input wire shared_sync_sleep_pin,
	input wire reference_buffer_pin,
	output reg [DRV_COUNT-1:0] output_driver_off,
	output reg chip_asleep,
	output reg channel_off,
	output reg bias_off,
	output reg clock_input_off,
	output reg ref_amplifier_off,
	output reg bandgap_off,
	output reg sync_pulse,
	output reg [1:0] reference_select,
	output reg reference_unused_code,
	output reg single_ended_clock_select,
	output reg diff_clock_buffer_off,
	output reg single_ended_analog_select,
	output reg delay_loop_off,
	output reg auto_zero_on
);

	// ----------------------------------------
	// register table
	// ----------------------------------------
	// six byte-wide registers, all read and write
	localparam NREG = 6;
	localparam DW = `ACFG_DATA_W;
	localparam AW = `ACFG_ADDR_W;

	// index order: drv low, drv mid, drv high, mask, sync/ref, analog
	localparam [NREG*AW-1:0] REG_OFFSETS = {
		`ACFG_OFF_ANALOG,
		`ACFG_OFF_SYNC_REF,
		`ACFG_OFF_PDN_MASK,
		`ACFG_OFF_DRV_HIGH,
		`ACFG_OFF_DRV_MID,
		`ACFG_OFF_DRV_LOW
	};
	localparam [NREG*DW-1:0] REG_RESETS = {
		`ACFG_RST_ANALOG,
		`ACFG_RST_SYNC_REF,
		`ACFG_RST_PDN_MASK,
		`ACFG_RST_DRV_HIGH,
		`ACFG_RST_DRV_MID,
		`ACFG_RST_DRV_LOW
	};

	// position of each register inside the flattened tables
	localparam IDX_DRV_LOW = 0;
	localparam IDX_DRV_MID = 1;
	localparam IDX_DRV_HIGH = 2;
	localparam IDX_MASK = 3;
	localparam IDX_SYNC_REF = 4;
	localparam IDX_ANALOG = 5;

	// ----------------------------------------
	// sync source decode codes
	// ----------------------------------------
	// one-hot: which path may launch a sync command right now
	localparam [2:0] SRC_SLEEP_PIN = 3'h1;
	localparam [2:0] SRC_SYNC_PIN = 3'h2;
	localparam [2:0] SRC_REGISTER = 3'h4;

	// flattened storage and per-register address matches
	wire [NREG*DW-1:0] cfg_flat;
	wire [NREG-1:0] cfg_hit;

	// ----------------------------------------
	// storage cells, one per register
	// ----------------------------------------
	// each cell decodes its own offset, so one write lands in one byte at most
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi = gi + 1) begin : g_cell
			acfg_cfg_reg #(
				.OFFSET(REG_OFFSETS[gi*AW +: AW]),
				.RESET_VALUE(REG_RESETS[gi*DW +: DW])
			) u_cell (
				.clock(clock),
				.rst(rst),
				.reg_addr(reg_addr),
				.reg_wdata(reg_wdata), // reserved bits stored as written
				.reg_we(reg_we),
				.value(cfg_flat[gi*DW +: DW]),
				.hit(cfg_hit[gi])
			);
		end
	endgenerate

	// named views of the stored bytes
	wire [DW-1:0] drv_low = cfg_flat[IDX_DRV_LOW*DW +: DW];
	wire [DW-1:0] drv_mid = cfg_flat[IDX_DRV_MID*DW +: DW];
	wire [DW-1:0] drv_high = cfg_flat[IDX_DRV_HIGH*DW +: DW];
	wire [DW-1:0] pdn_mask = cfg_flat[IDX_MASK*DW +: DW];
	wire [DW-1:0] sync_ref = cfg_flat[IDX_SYNC_REF*DW +: DW];
	wire [DW-1:0] analog_ctl = cfg_flat[IDX_ANALOG*DW +: DW];

	// ----------------------------------------
	// read-back
	// ----------------------------------------
	// if-chain over the hit lines; an unmapped offset reads as zero
	reg [DW-1:0] next_rdata;

	always @* begin
		if (cfg_hit[IDX_DRV_LOW]) begin
			next_rdata = drv_low;
		end else if (cfg_hit[IDX_DRV_MID]) begin
			next_rdata = drv_mid;
		end else if (cfg_hit[IDX_DRV_HIGH]) begin
			next_rdata = drv_high;
		end else if (cfg_hit[IDX_MASK]) begin
			next_rdata = pdn_mask;
		end else if (cfg_hit[IDX_SYNC_REF]) begin
			next_rdata = sync_ref;
		end else if (cfg_hit[IDX_ANALOG]) begin
			next_rdata = analog_ctl;
		end else begin
			next_rdata = `ACFG_RDATA_UNMAPPED;
		end
	end

	// read data held until the next read strobe
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= `ACFG_RDATA_UNMAPPED;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_re;
			if (reg_re) begin
				reg_rdata <= next_rdata; // reserved bits returned as stored
			end
		end
	end

	// ----------------------------------------
	// sync source selection
	// ----------------------------------------
	// decoded source, recomputed every cycle from the stored byte
	reg [2:0] sync_src;

	// register sync overrides the pin; otherwise bit 7 picks the pin role
	always @* begin
		if (sync_ref[`ACFG_SR_REG_SYNC_EN]) begin
			sync_src = SRC_REGISTER;
		end else if (sync_ref[`ACFG_SR_PIN_IS_SYNC]) begin
			sync_src = SRC_SYNC_PIN;
		end else begin
			sync_src = SRC_SLEEP_PIN;
		end
	end

	// ----------------------------------------
	// edge history of pin and sync bit
	// ----------------------------------------
	// history is kept in every mode so enabling a source later never
	// replays an old transition as a fresh command
	reg pin_prev;
	reg reg_sync_prev;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_prev <= 1'b0;
			reg_sync_prev <= 1'b0;
		end else begin
			pin_prev <= shared_sync_sleep_pin;
			reg_sync_prev <= sync_ref[`ACFG_SR_REG_SYNC];
		end
	end

	// rising pin edge; the pin arrives already synchronous to clock
	wire pin_rise = shared_sync_sleep_pin & ~pin_prev;
	// limitation: a toggle written while register sync is off is lost, not held
	// either direction counts: the bit is a toggle, not a pulse
	wire reg_toggle = sync_ref[`ACFG_SR_REG_SYNC] ^ reg_sync_prev;

	// ----------------------------------------
	// sync command
	// ----------------------------------------
	// sleep-pin mode never launches a sync, whatever the pin does
	reg next_sync;

	always @* begin
		case (sync_src)
			SRC_REGISTER: begin
				next_sync = reg_toggle;
			end
			SRC_SYNC_PIN: begin
				next_sync = pin_rise;
			end
			SRC_SLEEP_PIN: begin
				next_sync = 1'b0;
			end
			default: begin
				next_sync = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// whole-chip sleep and the mask
	// ----------------------------------------
	// the pin only means sleep while bit 7 is clear; with register
	// sync enabled bit 7 still decides the pin's power role
	wire pin_sleep = shared_sync_sleep_pin & ~sync_ref[`ACFG_SR_PIN_IS_SYNC];
	wire next_asleep = whole_chip_sleep | pin_sleep;

	// each exemption bit guards one block; the channel core has none
	wire next_bias_off = next_asleep & ~pdn_mask[`ACFG_MASK_KEEP_BIAS];
	wire next_clk_in_off = next_asleep & ~pdn_mask[`ACFG_MASK_KEEP_CLK];
	wire next_refamp_off = next_asleep & ~pdn_mask[`ACFG_MASK_KEEP_REFAMP];
	// inverted sense: set means the bandgap goes down too
	wire next_bg_off = next_asleep & pdn_mask[`ACFG_MASK_SLEEP_BG];

	// ----------------------------------------
	// reference and clock selection
	// ----------------------------------------
	// code 11 is passed through and flagged rather than remapped
	reg [1:0] next_ref;
	reg next_se_clk;

	// pin control knows only two choices: internal or buffered external
	always @* begin
		if (sync_ref[`ACFG_SR_REF_OWNER]) begin
			next_ref = sync_ref[`ACFG_SR_REF_SEL_HI:`ACFG_SR_REF_SEL_LO];
			next_se_clk = sync_ref[`ACFG_SR_SE_CLK];
		end else begin
			next_ref = reference_buffer_pin ? `ACFG_REF_EXT_BUFFERED : `ACFG_REF_INTERNAL;
			next_se_clk = 1'b0;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// every control leaves through a flop so the analog side never
	// sees decode glitches; cost is one cycle after the write
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			output_driver_off <= {DRV_COUNT{1'b0}};
			chip_asleep <= 1'b0;
			channel_off <= 1'b0;
			bias_off <= 1'b0;
			clock_input_off <= 1'b0;
			ref_amplifier_off <= 1'b0;
			bandgap_off <= 1'b0;
			sync_pulse <= 1'b0;
			reference_select <= `ACFG_REF_INTERNAL;
			reference_unused_code <= 1'b0;
			single_ended_clock_select <= 1'b0;
			diff_clock_buffer_off <= 1'b0;
			single_ended_analog_select <= 1'b0;
			delay_loop_off <= 1'b0;
			auto_zero_on <= 1'b0;
		end else begin
			// bit n of the map is pin driver n, 1 means off
			output_driver_off <= {drv_high, drv_mid, drv_low};
			chip_asleep <= next_asleep;
			channel_off <= next_asleep;
			bias_off <= next_bias_off;
			clock_input_off <= next_clk_in_off;
			ref_amplifier_off <= next_refamp_off;
			bandgap_off <= next_bg_off;
			sync_pulse <= next_sync;
			reference_select <= next_ref;
			reference_unused_code <= (next_ref == `ACFG_REF_UNUSED);
			single_ended_clock_select <= next_se_clk;
			diff_clock_buffer_off <= next_se_clk;
			single_ended_analog_select <= analog_ctl[`ACFG_AN_SE_INPUT];
			delay_loop_off <= analog_ctl[`ACFG_AN_DELAY_LOOP_OFF];
			auto_zero_on <= analog_ctl[`ACFG_AN_AUTO_ZERO];
		end
	end

endmodule

/* core/acfg_defines.vh */
`ifndef ACFG_DEFINES_VH
`define ACFG_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACFG_ADDR_W 8
`define ACFG_DATA_W 8
`define ACFG_OFF_DRV_LOW 8'h0A
`define ACFG_OFF_DRV_MID 8'h0B
`define ACFG_OFF_DRV_HIGH 8'h0C
`define ACFG_OFF_PDN_MASK 8'h0D
`define ACFG_OFF_SYNC_REF 8'h0E
`define ACFG_OFF_ANALOG 8'h11

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACFG_RST_DRV_LOW 8'h00
`define ACFG_RST_DRV_MID 8'h00
`define ACFG_RST_DRV_HIGH 8'h00
`define ACFG_RST_PDN_MASK 8'h00
`define ACFG_RST_SYNC_REF 8'h00
`define ACFG_RST_ANALOG 8'h00
`define ACFG_RDATA_UNMAPPED 8'h00

// ----------------------------------------
// power-down mask fields
// ----------------------------------------
`define ACFG_MASK_KEEP_BIAS 5
`define ACFG_MASK_KEEP_CLK 3
`define ACFG_MASK_KEEP_REFAMP 2
`define ACFG_MASK_SLEEP_BG 1

// ----------------------------------------
// sync and reference fields
// ----------------------------------------
`define ACFG_SR_PIN_IS_SYNC 7
`define ACFG_SR_REG_SYNC 6
`define ACFG_SR_REG_SYNC_EN 5
`define ACFG_SR_REF_OWNER 3
`define ACFG_SR_REF_SEL_HI 2
`define ACFG_SR_REF_SEL_LO 1
`define ACFG_SR_SE_CLK 0

// ----------------------------------------
// reference codes
// ----------------------------------------
`define ACFG_REF_INTERNAL 2'h0
`define ACFG_REF_EXT_BUFFERED 2'h1
`define ACFG_REF_EXTERNAL 2'h2
`define ACFG_REF_UNUSED 2'h3

// ----------------------------------------
// analog control fields
// ----------------------------------------
`define ACFG_AN_SE_INPUT 5
`define ACFG_AN_DELAY_LOOP_OFF 2
`define ACFG_AN_AUTO_ZERO 0

`endif

/* core/acfg_cfg_reg.v */
`timescale 1ns/10ps
`include "acfg_defines.vh"

// one byte of configuration storage at a fixed offset
module acfg_cfg_reg #(
	parameter [`ACFG_ADDR_W-1:0] OFFSET = 8'h00,
	parameter [`ACFG_DATA_W-1:0] RESET_VALUE = 8'h00
) (
	input wire clock,
	input wire rst,
	input wire [`ACFG_ADDR_W-1:0] reg_addr,
	input wire [`ACFG_DATA_W-1:0] reg_wdata,
	input wire reg_we,
	output reg [`ACFG_DATA_W-1:0] value,
	output wire hit
);

	// ----------------------------------------
	// decode and storage
	// ----------------------------------------
	// every bit is kept as written, reserved ones too
	assign hit = (reg_addr == OFFSET);

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			value <= RESET_VALUE;
		end else if (reg_we && hit) begin
			value <= reg_wdata;
		end
	end

endmodule

/* tb/acfg_host.sv */
`timescale 1ns/10ps
// ----
// host model of the register port
// ----
module acfg_host (
	input wire clock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire [7:0] reg_rdata,
	input wire reg_rvalid
);
	// idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_we = 1'h0;
		reg_re = 1'h0;
	end
	// one write, then a quiet cycle so strobes never re-rise in one step
	task wr(input [7:0] a, input [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'h1;
		@(posedge clock);
		#1 reg_we = 1'h0;
		reg_addr = ~a; // released lines never show the old value
		reg_wdata = ~d;
		@(posedge clock);
		#1;
	endtask
	// one read, answer taken just after the taking edge
	task rd(input [7:0] a, output [7:0] d, output v);
		reg_addr = a;
		reg_re = 1'h1;
		@(posedge clock);
		#1 d = reg_rdata;
		v = reg_rvalid;
		reg_re = 1'h0;
		reg_addr = ~a;
		@(posedge clock);
		#1;
	endtask
endmodule

/* tb/acfg_asserts.sv */
`timescale 1ns/10ps
// ----
// port checker
// ----
module acfg_asserts #(
	parameter DRV_COUNT = 24
) (
	input wire clock,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	input wire [7:0] reg_rdata,
	input wire reg_rvalid,
	input wire whole_chip_sleep,
	input wire shared_sync_sleep_pin,
	input wire reference_buffer_pin,
	input wire [DRV_COUNT-1:0] output_driver_off,
	input wire chip_asleep,
	input wire channel_off,
	input wire bias_off,
	input wire clock_input_off,
	input wire ref_amplifier_off,
	input wire bandgap_off,
	input wire sync_pulse,
	input wire [1:0] reference_select,
	input wire single_ended_clock_select
);
	logic [23:0] d;
	logic [7:0] m;
	logic [7:0] s;
	// shadow bytes fed from the write port
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			d <= 24'h000000;
			m <= 8'h00;
			s <= 8'h00;
		end else if (reg_we) begin
			case (reg_addr)
				8'h0A: d[7:0] <= reg_wdata;
				8'h0B: d[15:8] <= reg_wdata;
				8'h0C: d[23:16] <= reg_wdata;
				8'h0D: m <= reg_wdata;
				8'h0E: s <= reg_wdata;
				default: ;
			endcase
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	drv_map_a: assert property (output_driver_off == $past(d)) else $error("driver map wrong");
	sleep_cause_a: assert property (chip_asleep == ($past(whole_chip_sleep) |
		($past(shared_sync_sleep_pin) & !$past(s[7])))) else $error("sleep cause wrong");
	channel_down_a: assert property (channel_off == ($past(whole_chip_sleep) |
		($past(shared_sync_sleep_pin) & !$past(s[7])))) else $error("channel sleep wrong");
	bias_sleep_a: assert property (bias_off == (chip_asleep & !$past(m[5]))) else $error("bias wrong");
	clock_sleep_a: assert property (clock_input_off == (chip_asleep & !$past(m[3]))) else $error("clk wrong");
	refamp_sleep_a: assert property (ref_amplifier_off == (chip_asleep & !$past(m[2]))) else $error("amp");
	bandgap_sleep_a: assert property (bandgap_off == (chip_asleep & $past(m[1]))) else $error("bandgap");
	sync_source_a: assert property (sync_pulse == ($past(s[5]) ?
		($past(s[6]) != $past(s[6], 2)) :
		($past(s[7]) & $past(shared_sync_sleep_pin) & !$past(shared_sync_sleep_pin, 2))))
		else $error("sync pulse wrong");
	ref_select_a: assert property (reference_select == ($past(s[3]) ? $past(s[2:1]) :
		{1'h0, $past(reference_buffer_pin)})) else $error("reference wrong");
	se_clock_a: assert property (single_ended_clock_select == ($past(s[3]) & $past(s[0])))
		else $error("clock select wrong");
	read_valid_a: assert property (reg_rvalid == $past(reg_re)) else $error("read valid wrong");
	read_data_a: assert property (reg_re && reg_addr == 8'h0E |=> reg_rdata == $past(s))
		else $error("read data wrong");
endmodule

bind acfg_top acfg_asserts #(.DRV_COUNT(DRV_COUNT)) u_chk (.clock(clock), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .whole_chip_sleep(whole_chip_sleep), .shared_sync_sleep_pin(shared_sync_sleep_pin),
	.reference_buffer_pin(reference_buffer_pin), .output_driver_off(output_driver_off), .chip_asleep(chip_asleep),
	.channel_off(channel_off), .bias_off(bias_off), .clock_input_off(clock_input_off),
	.ref_amplifier_off(ref_amplifier_off), .bandgap_off(bandgap_off), .sync_pulse(sync_pulse),
	.reference_select(reference_select), .single_ended_clock_select(single_ended_clock_select));

/* tb/adc_power_sync_ref_config_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, v); end end
module adc_power_sync_ref_config_tb;
	logic clock = 0, rst = 1, slp = 0, pin = 0, rpin = 0, v;
	wire [7:0] addr, wd, rdata;
	wire we, re, rv, asl, chn, bia, cki, rfa, bgo, syp, ruc, sec, dcb, sea, dlo, azo;
	wire [23:0] drv;
	wire [1:0] rsel;
	int error_cnt = 0, checked = 0, cyc = 0, pulses = 0, i;
	logic [7:0] q;
	logic [7:0] amap [7] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h00};
	logic [7:0] masks [3] = '{8'h00, 8'h2E, 8'h24};
	acfg_host host (.clock(clock), .reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re),
		.reg_rdata(rdata), .reg_rvalid(rv));
	acfg_top DUT (.clock(clock), .rst(rst), .reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re),
		.reg_rdata(rdata), .reg_rvalid(rv), .whole_chip_sleep(slp), .shared_sync_sleep_pin(pin),
		.reference_buffer_pin(rpin), .output_driver_off(drv), .chip_asleep(asl), .channel_off(chn),
		.bias_off(bia), .clock_input_off(cki), .ref_amplifier_off(rfa), .bandgap_off(bgo), .sync_pulse(syp),
		.reference_select(rsel), .reference_unused_code(ruc), .single_ended_clock_select(sec),
		.diff_clock_buffer_off(dcb), .single_ended_analog_select(sea), .delay_loop_off(dlo), .auto_zero_on(azo));
	initial forever #4 clock = ~clock;
	// pulse counter and hang guard
	always @(posedge clock) begin
		cyc++;
		if (syp === 1'h1) pulses++;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict;
		end
	end
	task tick;
		@(posedge clock);
		#1;
	endtask
	task rdchk(input [7:0] a, input [7:0] e);
		host.rd(a, q, v);
		`CHK("rvalid", 1'h1, v)
		`CHK("rdata", e, q)
	endtask
	task drv3(input [7:0] a, input [7:0] b, input [7:0] c);
		host.wr(8'h0A, a);
		host.wr(8'h0B, b);
		host.wr(8'h0C, c);
		tick;
	endtask
	task give_verdict;
		if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (3) @(posedge clock);
		#1 rst = 0;
		for (i = 0; i < 7; i++) rdchk(amap[i], 8'h00); // cleared after reset, unmapped reads zero
		drv3(8'h60, 8'h1E, 8'h0C);
		`CHK("drv sdr", 24'h0C1E60, drv)
		drv3(8'hFF, 8'hEF, 8'hFC);
		`CHK("drv two lane", 24'hFCEFFF, drv)
		drv3(8'hFF, 8'hEF, 8'hFD);
		`CHK("drv one lane", 24'hFDEFFF, drv)
		rdchk(8'h0C, 8'hFD);
		host.wr(8'h11, 8'h25);
		tick;
		`CHK("analog", 3'h7, {sea, dlo, azo})
		rdchk(8'h11, 8'h25);
		slp = 1;
		for (i = 0; i < 3; i++) begin
			host.wr(8'h0D, masks[i]);
			tick;
			q = masks[i];
			`CHK("sleep", {2'h3, ~q[5], ~q[3], ~q[2], q[1]}, {asl, chn, bia, cki, rfa, bgo})
		end
		rdchk(8'h0D, 8'h24);
		slp = 0;
		tick;
		tick;
		`CHK("wake", 1'h0, asl)
		pin = 1;
		tick;
		tick;
		`CHK("pin sleep", 1'h1, asl)
		pin = 0;
		host.wr(8'h0E, 8'h80);
		pulses = 0;
		pin = 1;
		repeat (3) tick;
		`CHK("pin sync", 1, pulses)
		`CHK("pin no sleep", 1'h0, asl)
		pin = 0;
		pulses = 0;
		host.wr(8'h0E, 8'hE0);
		rdchk(8'h0E, 8'hE0);
		pin = 1;
		host.wr(8'h0E, 8'hA0);
		pin = 0;
		host.wr(8'h0E, 8'hC0);
		host.wr(8'h0E, 8'h80);
		repeat (3) tick;
		`CHK("reg sync", 2, pulses)
		host.wr(8'h0E, 8'h01);
		rpin = 1;
		tick;
		tick;
		`CHK("pin ref", 3'h2, {rsel, sec})
		rpin = 0;
		tick;
		tick;
		`CHK("pin ref", 2'h0, rsel)
		rpin = 1;
		for (i = 0; i < 8; i++) begin
			host.wr(8'h0E, {5'h01, i[2:0]});
			tick;
			`CHK("ref code", i[2:1], rsel)
			`CHK("unused code", &i[2:1], ruc)
			`CHK("se clock", {2{i[0]}}, {sec, dcb})
		end
		give_verdict;
	end
endmodule
